// ### common/sfs_defs.vh
// constants of the fault supervisor: map, codes, patterns, timing.
// assumes a 125 MHz clock and a 32-bit apb bus.
`ifndef SFS_DEFS_VH
`define SFS_DEFS_VH

// ****************************************************************
// register map and fields
// ****************************************************************
`define SFS_ADDR_W        8
`define SFS_OFF_CTRL      8'h00
`define SFS_OFF_STATUS    8'h04
`define SFS_CTRL_RESET    32'h0000_0000
`define SFS_CB_BYPCHK     0
`define SFS_CB_SOFTSTOP   1
`define SFS_CF_START_LSB  8
`define SFS_CF_STOP_LSB   16
`define SFS_CF_INIT_LSB   24
`define SFS_LEVEL_MAX     8'hff

// ****************************************************************
// timing
// ****************************************************************
`define SFS_CLK_PERIOD_NS 8
`define SFS_MS_NS         1000000
`define SFS_MS_CYC        (`SFS_MS_NS / `SFS_CLK_PERIOD_NS)
`define SFS_CLOSE_MS      100
`define SFS_REL_MS        500
`define SFS_FLASH_MS      250

// ****************************************************************
// fault codes
// ****************************************************************
`define SFS_F_NONE   4'h0
`define SFS_F_LOWV   4'h1
`define SFS_F_LINE   4'h2
`define SFS_F_LOAD   4'h3
`define SFS_F_BYP    4'h4
`define SFS_F_CLOS   4'h5
`define SFS_F_MCU    4'h6
`define SFS_F_MLAT   4'h7
`define SFS_F_LLAT   4'h8
`define SFS_F_PHRUN  4'h9

// ****************************************************************
// indicator colours and patterns {supply,line,load,bypass,diag}
// ****************************************************************
`define SFS_C_OFF    3'h0
`define SFS_C_GRN    3'h1
`define SFS_C_RED    3'h2
`define SFS_C_FGRN   3'h3
`define SFS_C_FRED   3'h4
`define SFS_P_IDLE   15'h1240
`define SFS_P_START  15'h12c0
`define SFS_P_FULL   15'h1248
`define SFS_P_STOP   15'h1640
`define SFS_P_LOWV   15'h2002
`define SFS_P_LINE   15'h1402
`define SFS_P_PHRUN  15'h184a
`define SFS_P_LOAD   15'h1082
`define SFS_P_BYP    15'h1912
`define SFS_P_CLOS   15'h1802
`define SFS_P_MCU    15'h2482
`define SFS_P_MLAT   15'h4802
`define SFS_P_LLAT   15'h4102
`define SFS_P_NONE   15'h0000

`endif

// ### hdl/sfs_sync.v
// two-stage synchroniser for asynchronous pin levels.
// assumes slow levels; no glitch filter.
`timescale 1ns/1ns

module sfs_sync #(
   parameter WIDTH = 1
) (
   input  wire             clock_i,
   input  wire             rst_n_i,
   input  wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] sync_reg;

   // first stage feeds only the second stage
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= {WIDTH{1'b0}};
         sync_reg <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;

endmodule

// ### hdl/sfs_supervisor.v
// soft starter fault supervisor: sequencing, faults,
// latching, indicators and an apb slave.
// assumes asynchronous sensing pins and a
// same-clock mcu_fault_i from a watchdog.
// Contract
// R1 - full diagnostic whenever supply is sufficient
// R2 - ramps and full-on check phases, closure only
// R3 - control overrides diagnostic outcome
// R4 - fault under control closes all switches
// R5 - full-on shows pattern of persisting fault
// R6 - fault in soft-stop aborts to off-diagnostic
// R7 - cleared mains fault under control latches stop
// R8 - cleared load fault under control latches stop
// R9 - bypass check option stops, flags bypass fault
// R10 - missing load or shorted thyristor stops
// R11 - phase, frequency, interference faults stop
// R12 - low mains voltage stops with indication
// R13 - switches failing to close stop motor
// R14 - internal malfunction locks until power removed; the code leaves the lock only on reset, not when supply_ok_i drops
// R15 - residual back-emf blocks reconnection
// R16 - operator should prefer soft-stop
// R17 - healthy mains, motor, control start ramp
// R18 - each fault has a unique indicator pattern
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`include "sfs_defs.vh"

module sfs_supervisor #(
   parameter TICK_CYC  = `SFS_MS_CYC,
   parameter CLOSE_MS  = `SFS_CLOSE_MS,
   parameter REL_MS    = `SFS_REL_MS,
   parameter FLASH_MS  = `SFS_FLASH_MS
) (
   input  wire        clock_i,
   input  wire        rst_n_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [7:0]  paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output wire        pready_o,
   output wire        pslverr_o,
   input  wire        supply_ok_i,
   input  wire        mains_volt_ok_i,
   input  wire        phases_ok_i,
   input  wire        freq_ok_i,
   input  wire        noise_high_i,
   input  wire        residual_v_i,
   input  wire        load_present_i,
   input  wire        thy_short_i,
   input  wire        bypass_present_i,
   input  wire        control_i,
   input  wire        estop_closed_i,
   input  wire        switches_closed_i,
   input  wire        mcu_fault_i,
   output reg         thy_on_o,
   output reg         thy_full_o,
   output reg  [7:0]  level_o,
   output reg         bypass_o,
   output reg         diag_o,
   output reg  [1:0]  led_supply_o,
   output reg  [1:0]  led_line_o,
   output reg  [1:0]  led_load_o,
   output reg  [1:0]  led_byp_o,
   output reg  [1:0]  led_diag_o
);

   // ****************************************************************
   // states
   // ****************************************************************
   localparam [5:0] ST_DIAG  = 6'h01;
   localparam [5:0] ST_START = 6'h02;
   localparam [5:0] ST_FULL  = 6'h04;
   localparam [5:0] ST_STOP  = 6'h08;
   localparam [5:0] ST_FAULT = 6'h10;
   localparam [5:0] ST_LOCK  = 6'h20;

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   wire [11:0] pins_s;
   sfs_sync #(.WIDTH(12)) u_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .async_i ({supply_ok_i, mains_volt_ok_i, phases_ok_i, freq_ok_i,
                 noise_high_i, residual_v_i, load_present_i, thy_short_i,
                 bypass_present_i, control_i, estop_closed_i,
                 switches_closed_i}),
      .sync_o  (pins_s)
   );
   wire supply_s = pins_s[11];
   wire mvolt_s  = pins_s[10];
   wire phase_s  = pins_s[9];
   wire freq_s   = pins_s[8];
   wire noise_s  = pins_s[7];
   wire resid_s  = pins_s[6];
   wire load_s   = pins_s[5];
   wire short_s  = pins_s[4];
   wire byp_s    = pins_s[3];
   wire ctrl_s   = pins_s[2];
   wire estop_s  = pins_s[1];
   wire closed_s = pins_s[0];

   // ****************************************************************
   // register file
   // ****************************************************************
   reg  [31:0] ctrl_reg;
   reg  [5:0]  state_reg;
   reg  [3:0]  code_reg;
   reg         latch_reg;
   wire        bypchk_en = ctrl_reg[`SFS_CB_BYPCHK];
   wire        sstop_en  = ctrl_reg[`SFS_CB_SOFTSTOP];
   wire [7:0]  start_ms  = ctrl_reg[`SFS_CF_START_LSB +: 8];
   wire [7:0]  stop_ms   = ctrl_reg[`SFS_CF_STOP_LSB +: 8];
   wire [7:0]  init_lvl  = ctrl_reg[`SFS_CF_INIT_LSB +: 8];
   wire        hit_ctrl  = (paddr_i == `SFS_OFF_CTRL);
   wire        hit_stat  = (paddr_i == `SFS_OFF_STATUS);
   wire        access    = psel_i & penable_i;

   // no wait states; refuse unmapped or status writes
   assign pready_o  = 1'b1;
   assign pslverr_o = access & ~(hit_ctrl | (hit_stat & ~pwrite_i));

   // write at the access edge, read data staged during setup
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_reg <= `SFS_CTRL_RESET;
         prdata_o <= 32'h0000_0000;
      end else begin
         if (access & pwrite_i & hit_ctrl) begin
            ctrl_reg <= pwdata_i;
         end
         if (psel_i & ~penable_i) begin
            if (hit_ctrl) begin
               prdata_o <= ctrl_reg;
            end else if (hit_stat) begin
               prdata_o <= {level_o, 7'h00, latch_reg, 4'h0, code_reg,
                            2'h0, state_reg};
            end else begin
               prdata_o <= 32'h0000_0000;
            end
         end
      end
   end

   // ****************************************************************
   // millisecond tick and timers
   // ****************************************************************
   reg [31:0] tick_cnt_reg;
   reg        tick_reg;
   reg [15:0] step_cnt_reg;
   reg [15:0] close_cnt_reg;
   reg [15:0] rel_cnt_reg;
   reg [15:0] flash_cnt_reg;
   reg        flash_reg;
   wire       ramp_run  = (state_reg == ST_START) | (state_reg == ST_STOP);
   wire [7:0] step_ms   = (state_reg == ST_STOP) ? stop_ms : start_ms;
   wire       step_due  = tick_reg & (step_cnt_reg >= {8'h00, step_ms});
   wire       close_flt = (close_cnt_reg >= CLOSE_MS[15:0]);
   wire       rel_done  = (rel_cnt_reg >= REL_MS[15:0]);

   // slow rates are enables, never derived clocks
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_cnt_reg  <= 32'h0000_0000;
         tick_reg      <= 1'b0;
         step_cnt_reg  <= 16'h0000;
         close_cnt_reg <= 16'h0000;
         rel_cnt_reg   <= 16'h0000;
         flash_cnt_reg <= 16'h0000;
         flash_reg     <= 1'b0;
      end else begin
         tick_reg <= (tick_cnt_reg == TICK_CYC[31:0] - 32'h1);
         if (tick_cnt_reg == TICK_CYC[31:0] - 32'h1) begin
            tick_cnt_reg <= 32'h0000_0000;
         end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
         end
         if (!ramp_run | step_due) begin
            step_cnt_reg <= 16'h0000;
         end else if (tick_reg) begin
            step_cnt_reg <= step_cnt_reg + 16'h1;
         end
         // closure watchdog runs only while switches are commanded on
         if (!thy_on_o | closed_s) begin
            close_cnt_reg <= 16'h0000;
         end else if (tick_reg & ~close_flt) begin
            close_cnt_reg <= close_cnt_reg + 16'h1;
         end
         // control must stay removed for the whole release time
         if (ctrl_s) begin
            rel_cnt_reg <= 16'h0000;
         end else if (tick_reg & ~rel_done) begin
            rel_cnt_reg <= rel_cnt_reg + 16'h1;
         end
         if (tick_reg) begin
            if (flash_cnt_reg >= FLASH_MS[15:0] - 16'h1) begin
               flash_cnt_reg <= 16'h0000;
               flash_reg     <= ~flash_reg;
            end else begin
               flash_cnt_reg <= flash_cnt_reg + 16'h1;
            end
         end
      end
   end

   // ****************************************************************
   // fault classification
   // ****************************************************************
   reg [3:0] off_code;
   reg [3:0] run_code;

   // stopped: whole diagnostic in priority order   [R1]
   always @* begin
      off_code = `SFS_F_NONE;
      if (!mvolt_s) begin
         off_code = `SFS_F_LOWV;                           // [R12]
      end else if (!phase_s | !freq_s | noise_s | resid_s) begin
         off_code = `SFS_F_LINE;                           // [R11] [R15]
      end else if (!load_s | short_s) begin
         off_code = `SFS_F_LOAD;                           // [R10]
      end else if (bypchk_en & ~byp_s) begin
         off_code = `SFS_F_BYP;                            // [R9]
      end else if (!estop_s) begin
         off_code = `SFS_F_CLOS;                           // [R13]
      end
   end

   // driving: only phase presence and switch closure are watched   [R2]
   always @* begin
      run_code = `SFS_F_NONE;
      if (!phase_s) begin
         run_code = `SFS_F_PHRUN;
      end else if (!estop_s | close_flt) begin
         run_code = `SFS_F_CLOS;                           // [R13]
      end
   end

   // ****************************************************************
   // sequencer
   // ****************************************************************
   reg [5:0] state_next;
   reg [3:0] code_next;
   reg       latch_next;
   reg [7:0] level_next;

   always @* begin
      state_next = state_reg;
      code_next  = code_reg;
      latch_next = latch_reg;
      level_next = level_o;
      case (state_reg)
         ST_DIAG: begin
            code_next  = off_code;
            level_next = 8'h00;
            if (off_code != `SFS_F_NONE) begin
               state_next = ST_FAULT;
            end else if (ctrl_s) begin
               state_next = ST_START;                      // [R17]
               level_next = init_lvl;
            end
         end
         ST_START, ST_FULL: begin
            // faults only flag; control keeps the motor driven   [R3]
            if (run_code != `SFS_F_NONE) begin
               code_next = run_code;
            end
            if (!ctrl_s) begin
               code_next  = `SFS_F_NONE;
               state_next = sstop_en ? ST_STOP : ST_DIAG;  // [R16]
               if (!sstop_en) begin
                  level_next = 8'h00;
               end
            end else if (state_reg == ST_START) begin
               if (level_o == `SFS_LEVEL_MAX) begin
                  state_next = ST_FULL;
               end else if (step_due) begin
                  level_next = level_o + 8'h01;
               end
            end
         end
         ST_STOP: begin
            if (run_code != `SFS_F_NONE) begin
               state_next = ST_DIAG;                       // [R6]
               level_next = 8'h00;
            end else if (ctrl_s) begin
               state_next = ST_START;
            end else if (level_o == 8'h00) begin
               state_next = ST_DIAG;
            end else if (step_due) begin
               level_next = level_o - 8'h01;
            end
         end
         ST_FAULT: begin
            level_next = 8'h00;
            if (off_code != `SFS_F_NONE) begin
               if (!latch_reg) begin
                  code_next = off_code;
               end
            end else if (latch_reg) begin
               if (rel_done) begin
                  latch_next = 1'b0;
                  state_next = ST_DIAG;
               end
            end else if (ctrl_s & ((code_reg == `SFS_F_LOWV) |
                                   (code_reg == `SFS_F_LINE))) begin
               latch_next = 1'b1;                          // [R7]
               code_next  = `SFS_F_MLAT;
            end else if (ctrl_s & (code_reg == `SFS_F_LOAD)) begin
               latch_next = 1'b1;                          // [R8]
               code_next  = `SFS_F_LLAT;
            end else begin
               state_next = ST_DIAG;
               code_next  = `SFS_F_NONE;
            end
         end
         ST_LOCK: begin
            level_next = 8'h00;
            code_next  = `SFS_F_MCU;
         end
         default: begin
            state_next = ST_DIAG;
            code_next  = `SFS_F_NONE;
            latch_next = 1'b0;
            level_next = 8'h00;
         end
      endcase
      // malfunction wins; only reset leaves it
      if (mcu_fault_i | (state_reg == ST_LOCK)) begin
         state_next = ST_LOCK;                             // [R14]
         code_next  = `SFS_F_MCU;
         level_next = 8'h00;
      end else if (!supply_s) begin
         state_next = ST_DIAG;
         code_next  = `SFS_F_NONE;
         latch_next = 1'b0;
         level_next = 8'h00;
      end
   end

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= ST_DIAG;
         code_reg  <= `SFS_F_NONE;
         latch_reg <= 1'b0;
         level_o   <= 8'h00;
      end else begin
         state_reg <= state_next;
         code_reg  <= code_next;
         latch_reg <= latch_next;
         level_o   <= level_next;
      end
   end

   // ****************************************************************
   // outputs and indicators
   // ****************************************************************
   reg [14:0] pat;

   // pick one unique pattern per condition   [R18]
   always @* begin
      pat = `SFS_P_IDLE;
      case (code_reg)
         `SFS_F_LOWV:  pat = `SFS_P_LOWV;
         `SFS_F_LINE:  pat = `SFS_P_LINE;
         `SFS_F_LOAD:  pat = `SFS_P_LOAD;
         `SFS_F_BYP:   pat = `SFS_P_BYP;
         `SFS_F_CLOS:  pat = `SFS_P_CLOS;
         `SFS_F_MCU:   pat = `SFS_P_MCU;
         `SFS_F_MLAT:  pat = `SFS_P_MLAT;
         `SFS_F_LLAT:  pat = `SFS_P_LLAT;
         `SFS_F_PHRUN: pat = `SFS_P_PHRUN;
         default:      pat = `SFS_P_IDLE;
      endcase
      // ramps show the motor state, not the fault
      if (state_reg == ST_START) begin
         pat = `SFS_P_START;
      end else if (state_reg == ST_STOP) begin
         pat = `SFS_P_STOP;
      end else if ((state_reg == ST_FULL) & (code_reg == `SFS_F_NONE)) begin
         pat = `SFS_P_FULL;
      end
      if (!supply_s) begin
         pat = `SFS_P_NONE;
      end
   end

   // colour code to {red, green} drive with the shared flash phase
   function [1:0] led_drv;
      input [2:0] c;
      input       f;
      begin
         case (c)
            `SFS_C_GRN:  led_drv = 2'b01;
            `SFS_C_RED:  led_drv = 2'b10;
            `SFS_C_FGRN: led_drv = {1'b0, f};
            `SFS_C_FRED: led_drv = {f, 1'b0};
            default:     led_drv = 2'b00;
         endcase
      end
   endfunction

   wire driving = (state_reg == ST_START) | (state_reg == ST_FULL) |
                  (state_reg == ST_STOP);

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         thy_on_o     <= 1'b0;
         thy_full_o   <= 1'b0;
         bypass_o     <= 1'b0;
         diag_o       <= 1'b0;
         led_supply_o <= 2'b00;
         led_line_o   <= 2'b00;
         led_load_o   <= 2'b00;
         led_byp_o    <= 2'b00;
         led_diag_o   <= 2'b00;
      end else begin
         thy_on_o     <= driving;
         // a fault under control drives every switch fully on   [R4]
         thy_full_o   <= driving & (state_reg != ST_STOP) &
                         ((code_reg != `SFS_F_NONE) | (state_reg == ST_FULL));
         bypass_o     <= (state_reg == ST_FULL);
         diag_o       <= (code_reg != `SFS_F_NONE);
         // persisting fault in full-on shows its own pattern   [R5]
         led_supply_o <= led_drv(pat[14:12], flash_reg);
         led_line_o   <= led_drv(pat[11:9], flash_reg);
         led_load_o   <= led_drv(pat[8:6], flash_reg);
         led_byp_o    <= led_drv(pat[5:3], flash_reg);
         led_diag_o   <= led_drv(pat[2:0], flash_reg);
      end
   end

endmodule

// ### verification/sfs_plant.sv
// far side: mains, motor windings, urgent-stop loop.
// assumes fault_i from the bench, bit 0 low mains to bit 4 open loop.
`timescale 1ns/1ns
module sfs_plant #(
   parameter RES_CYC = 30
) (
   input  wire         clock_i,
   input  wire         rst_n_i,
   input  wire         thy_on_i,
   input  wire [7:0]   level_i,
   input  wire [4:0]   fault_i,
   output wire         mains_volt_ok_o,
   output wire         phases_ok_o,
   output wire         load_present_o,
   output wire         thy_short_o,
   output wire         estop_closed_o,
   output logic        switches_closed_o,
   output wire         residual_v_o
);
   // *****
   // plant
   // *****
   logic [7:0] res_cnt_reg;
   logic [7:0] lvl_d_reg;
   // sensed levels follow the commanded plant faults
   assign mains_volt_ok_o = !fault_i[0];
   assign phases_ok_o     = !fault_i[1];
   assign load_present_o  = !fault_i[2];
   assign thy_short_o     = fault_i[3];
   assign estop_closed_o  = !fault_i[4];
   assign residual_v_o    = res_cnt_reg != 8'h00;
   // switches conduct only with the loop closed and a motor fitted
   // a hard stop leaves back-emf; a ramp to zero leaves none
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         switches_closed_o <= 1'b0;
         lvl_d_reg         <= 8'h00;
         res_cnt_reg       <= 8'h00;
      end else begin
         switches_closed_o <= thy_on_i & !fault_i[4] & !fault_i[2];
         lvl_d_reg         <= level_i;
         if (lvl_d_reg > 8'h01 && level_i == 8'h00)
            res_cnt_reg <= 8'(RES_CYC);
         else if (res_cnt_reg != 8'h00)
            res_cnt_reg <= res_cnt_reg - 8'h01;
      end
   end
endmodule

// ### verification/sfs_sup_checker.sv
// port assertions: apb answers and motor sequencing.
// assumes binding into sfs_supervisor.
`timescale 1ns/1ns
module sfs_sup_checker (
   input logic       clock_i,
   input logic       rst_n_i,
   input logic       psel_i,
   input logic       penable_i,
   input logic [7:0] paddr_i,
   input logic       pslverr_o,
   input logic       supply_ok_i,
   input logic       control_i,
   input logic       mains_volt_ok_i,
   input logic       phases_ok_i,
   input logic       load_present_i,
   input logic       mcu_fault_i,
   input logic       thy_on_o,
   input logic       thy_full_o,
   input logic       bypass_o,
   input logic [7:0] level_o,
   input logic [1:0] led_supply_o,
   input logic [1:0] led_line_o,
   input logic [1:0] led_load_o,
   input logic [1:0] led_byp_o,
   input logic [1:0] led_diag_o
);
   // *****
   // rules
   // *****
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   wire [9:0] leds_w = {led_supply_o, led_line_o, led_load_o, led_byp_o, led_diag_o};
   // eight cycles outlast sync and state latency
   sequence s_ctl_idle; !control_i [*8]; endsequence
   sequence s_lowv; !mains_volt_ok_i [*8]; endsequence
   sequence s_nophase; !phases_ok_i [*8]; endsequence
   sequence s_noload; !load_present_i [*8]; endsequence
   // lock pattern must persist, not flash by
   sequence s_mcu_shown; (leds_w == 10'h2a2) [*8]; endsequence
   err_in_access_a: assert property (pslverr_o |-> psel_i && penable_i)
      else $error("slave error outside access phase");
   unmapped_err_a: assert property (psel_i && penable_i && paddr_i != 8'h00
      && paddr_i != 8'h04 |-> pslverr_o) else $error("unmapped access not refused");
   full_in_drive_a: assert property (thy_full_o |-> thy_on_o)
      else $error("switches closed while not driving");
   bypass_full_a: assert property (bypass_o |-> thy_full_o && $past(level_o) == 8'hff)
      else $error("bypass output before full level");
   start_needs_ctl_a: assert property (s_ctl_idle |=> !$rose(thy_on_o))
      else $error("drive began without control");
   lowv_blocks_a: assert property (s_lowv |=> !$rose(thy_on_o))
      else $error("drive began on low mains");
   phase_blocks_a: assert property (s_nophase |=> !$rose(thy_on_o))
      else $error("drive began with phase missing");
   load_blocks_a: assert property (s_noload |=> !$rose(thy_on_o))
      else $error("drive began without motor");
   mcu_lock_a: assert property ($rose(mcu_fault_i) && supply_ok_i |-> ##[1:4] s_mcu_shown)
      else $error("controller fault pattern missing");
endmodule
bind sfs_supervisor sfs_sup_checker chk (.*);

// ### verification/softstarter_fault_supervisor_test.sv
// self-checking bench with the plant model beside it.
// assumes short ms ticks; bench owns control, supply, faults.
`timescale 1ns/1ns
`include "sfs_defs.vh"
`define CK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module softstarter_fault_supervisor_test;
   logic clk, rst_n, psel, pen, pwr, supply, ctl, mcu, err;
   logic [7:0] paddr, init, f;
   logic [31:0] pwdata, rd;
   wire [31:0] prdata;
   wire pready, pslverr, mv, ph, ld, sh, es, sw, rv, on, full, byp, diag;
   wire [7:0] level;
   wire [1:0] l0, l1, l2, l3, l4;
   wire [9:0] leds = {l0, l1, l2, l3, l4};
   int error_cnt, tests_run, seed, cyc, i, k;
   logic [3:0] tbl [8];
   sfs_supervisor #(.TICK_CYC(10), .CLOSE_MS(3), .REL_MS(5), .FLASH_MS(2)) dut (
      .clock_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .supply_ok_i(supply), .mains_volt_ok_i(mv), .phases_ok_i(ph),
      .freq_ok_i(!f[5]), .noise_high_i(f[6]), .residual_v_i(rv), .load_present_i(ld),
      .thy_short_i(sh), .bypass_present_i(!f[7]), .control_i(ctl), .estop_closed_i(es),
      .switches_closed_i(sw), .mcu_fault_i(mcu), .thy_on_o(on), .thy_full_o(full),
      .level_o(level), .bypass_o(byp), .diag_o(diag), .led_supply_o(l0), .led_line_o(l1),
      .led_load_o(l2), .led_byp_o(l3), .led_diag_o(l4));
   sfs_plant plant (.clock_i(clk), .rst_n_i(rst_n), .thy_on_i(on), .level_i(level),
      .fault_i(f[4:0]), .mains_volt_ok_o(mv), .phases_ok_o(ph), .load_present_o(ld),
      .thy_short_o(sh), .estop_closed_o(es), .switches_closed_o(sw), .residual_v_o(rv));
   // *****
   // helpers
   // *****
   function automatic [1:0] col(input [2:0] c);
      col = (c == `SFS_C_GRN) ? 2'b01 : (c == `SFS_C_RED) ? 2'b10 : 2'b00;
   endfunction
   function automatic [9:0] pat(input [2:0] a, b, c, d, e);
      pat = {col(a), col(b), col(c), col(d), col(e)};
   endfunction
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // request held until pready high
   task automatic apb(input logic w, input [7:0] a, input [31:0] d);
      @(posedge clk);
      psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic code(input [3:0] c);
      apb(1'b0, 8'h04, 32'h0);
      `CK("code", c, rd[11:8])
   endtask
   task automatic setf(input [7:0] v);
      @(posedge clk) f <= v;
   endtask
   task automatic setc(input logic v);
      @(posedge clk) ctl <= v;
   endtask
   // bounded full-on wait
   task automatic wfull();
      for (i = 0; i < 3000 && byp !== 1'b1; i++) @(posedge clk);
      `CK("full_on", 1'b1, byp)
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   // a hang is cut short well beyond the longest ramp
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         results();
      end
   end
   // *****
   // scenarios
   // *****
   initial begin
      seed = 93; rst_n = 0; psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0;
      supply = 1; ctl = 0; mcu = 0; f = 0;
      tbl = '{`SFS_F_LOWV, `SFS_F_LINE, `SFS_F_LOAD, `SFS_F_LOAD, `SFS_F_CLOS,
              `SFS_F_LINE, `SFS_F_LINE, `SFS_F_BYP};
      wt(8);
      rst_n <= 1'b1;
      wt(6);
      apb(1'b0, 8'h00, 32'h0); `CK("ctrl_reset", `SFS_CTRL_RESET, rd)
      apb(1'b0, 8'h10, 32'h0); `CK("unmapped", 1'b1, err)
      apb(1'b1, 8'h04, 32'h0); `CK("status_ro", 1'b1, err)
      init = 8'hf0 | 8'($random(seed) & 8'h0f);
      apb(1'b1, 8'h00, {init, 24'h000002});
      setc(1'b1); wfull(); `CK("level", 8'hff, level)
      `CK("full_pat", pat(1, 1, 1, 1, 0), leds)
      setf(8'h02); wt(40); `CK("runs", 1'b1, on)
      `CK("closed", 1'b1, full)
      code(`SFS_F_PHRUN);
      setf(8'h00); wt(10); setc(1'b0); wt(12);
      `CK("ramp_down", 1'b1, on)
      setf(8'h02); wt(12); `CK("aborted", 1'b0, on)
      `CK("level_off", 8'h00, level)
      setf(8'h00); wt(40);
      // transient mains and load faults under control latch a stop
      for (k = 0; k < 3; k++) begin
         setf(8'h01 << k); setc(1'b1); wt(20);
         setf(8'h00); wt(20); code(k < 2 ? `SFS_F_MLAT : `SFS_F_LLAT);
         `CK("held", 1'b0, on)
         setc(1'b0); wt(80); code(`SFS_F_NONE);
      end
      apb(1'b1, 8'h00, {init, 24'h000003});
      for (k = 0; k < 8; k++) begin
         setf(8'h01 << k); wt(20); code(tbl[k]);
         setf(8'h00); wt(20);
      end
      apb(1'b1, 8'h00, {init, 24'h000000});
      setf(8'h80); wt(20); code(`SFS_F_NONE);
      setf(8'h00); setc(1'b1); wfull();
      setc(1'b0); wt(6); code(`SFS_F_LINE);
      wt(60); code(`SFS_F_NONE);
      supply <= 1'b0; wt(10); `CK("dark", 10'h000, leds)
      supply <= 1'b1; wt(10);
      @(posedge clk) mcu <= 1'b1;
      @(posedge clk) mcu <= 1'b0;
      wt(10); code(`SFS_F_MCU);
      setc(1'b1); wt(30); `CK("locked", 1'b0, on)
      setc(1'b0); rst_n <= 1'b0; wt(2); rst_n <= 1'b1; wt(6);
      code(`SFS_F_NONE);
      results();
   end
endmodule
